// ### shared/timer_compare_pkg.sv
// timer compare package: register offsets, fields, reset values, mode and action codes
// assumes an 8-bit timer count supplied by a separate counter block
package timer_compare_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_CONTROL    = 3'h0;
	localparam logic [2:0] REG_COMPARE_A  = 3'h1;
	localparam logic [2:0] REG_COMPARE_B  = 3'h2;
	localparam logic [2:0] REG_FLAGS      = 3'h3;
	localparam logic [2:0] REG_INT_ENABLE = 3'h4;
	localparam logic [2:0] REG_FORCE      = 3'h5;
	localparam logic [2:0] REG_STATUS     = 3'h6;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_ACT_LSB   = 4;
	localparam int STAT_LATCH_LSB = 0;
	localparam int STAT_BLOCK_BIT = 2;
	localparam logic [7:0] CONTROL_MASK = 8'hF7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [1:0] ENABLE_RESET  = 2'h0;

	// ----------------------------------------------------------------
	// waveform mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_NORMAL   = 3'h0;
	localparam logic [2:0] MODE_PC_MAX   = 3'h1;
	localparam logic [2:0] MODE_CLEAR    = 3'h2;
	localparam logic [2:0] MODE_FAST_MAX = 3'h3;
	localparam logic [2:0] MODE_PC_CMP   = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;

	// ----------------------------------------------------------------
	// action select codes and count limits
	// ----------------------------------------------------------------
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
	localparam logic [7:0] COUNT_MAX    = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;

endpackage

// ### verilog/timer_output_compare_waveform.sv
// output compare and waveform latch logic for two channels of an 8-bit timer
// assumes the counter, its direction and its write strobe come from a separate block
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - compare count with both compare values every timer tick; equality is a match
// - compare flag sets one timer tick after the match tick
// - flag with enable raises interrupt; servicing acknowledgement clears the flag
// - writing one to a flag bit clears it; zero leaves it
// - compare values buffered in PWM modes, written directly in other modes
// - buffered value moves to active compare only at top
// - software reads and writes the buffer when buffered, else the active value
// - force strobe in non-PWM modes acts like a match without flag
// - a count write suppresses all matches at the next timer tick
// - waveform latch keeps its value across mode changes
// - action select changes act unbuffered at the next match or force
// - nonzero action select drives the pin from the latch, except PWM action 01 when reserved; direction unchanged
// - action select zero does nothing to the latch and frees the pin
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clears on match, sets at bottom; 11 inverted
// - PWM action 01: channel A toggles only with top bit set; B reserved
// - phase correct: 10 clears on up match, sets on down match; 11 inverted
// - compare equal to top with high action bit: match ignored, act at bottom/top
// - phase correct: compare leaving max gives up-match result at bottom
// - phase correct: missed upward match still transitions at bottom
// - mode 2 clear on match, 3 fast PWM top max, 7 fast top compare A
// - modes 1 and 5 phase correct with top max or compare A
module timer_output_compare_waveform
	import timer_compare_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic              timer_tick,
	input  wire logic [DATA_W-1:0] timer_count_value,
	input  wire logic              count_down,
	input  wire logic              count_write,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              int_ack_a,
	input  wire logic              int_ack_b,
	output logic                   irq_a,
	output logic                   irq_b,
	input  wire logic              port_value_a,
	input  wire logic              port_value_b,
	input  wire logic              dir_out_a,
	input  wire logic              dir_out_b,
	output logic                   waveform_output_a,
	output logic                   waveform_output_b,
	output logic                   pin_out_a,
	output logic                   pin_oe_a,
	output logic                   pin_out_b,
	output logic                   pin_oe_b
);

	// ----------------------------------------------------------------
	// state and decode signals
	// ----------------------------------------------------------------
	logic [7:0]          control;
	logic [2:0]          waveform_mode_select;
	logic                waveform_mode_top_bit;
	logic                is_fast;
	logic                is_phase;
	logic                is_pwm;
	logic [7:0]          top_value;
	logic                at_top;
	logic                at_bottom;
	logic                block_pending;
	logic [CHANNELS-1:0] int_enable;
	logic [CHANNELS-1:0] int_ack;
	logic [CHANNELS-1:0] dir_out;
	logic [CHANNELS-1:0] port_value;
	logic [CHANNELS-1:0] irq;
	logic [CHANNELS-1:0] hit;
	logic [CHANNELS-1:0] ignore_match;
	logic [CHANNELS-1:0] match_pend;
	logic [CHANNELS-1:0] compare_flag_channel;
	logic [CHANNELS-1:0] force_compare_strobe;
	logic [CHANNELS-1:0] waveform_output_latch;
	logic [CHANNELS-1:0] next_latch;
	logic [CHANNELS-1:0] connected;
	logic [CHANNELS-1:0] pin_out;
	logic [CHANNELS-1:0] up_seen;
	logic [CHANNELS-1:0] sym_fix;
	logic [CHANNELS-1:0] update_point;
	logic [1:0]          compare_action_select [CHANNELS];
	logic [7:0]          compare_value_channel [CHANNELS];
	logic [7:0]          compare_buffer        [CHANNELS];
	logic [7:0]          next_rdata;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign waveform_mode_select  = control[CTRL_MODE_LSB +: 3];
	assign waveform_mode_top_bit = waveform_mode_select[2];
	assign is_fast  = (waveform_mode_select == MODE_FAST_MAX)
		|| (waveform_mode_select == MODE_FAST_CMP);
	assign is_phase = (waveform_mode_select == MODE_PC_MAX)
		|| (waveform_mode_select == MODE_PC_CMP);
	assign is_pwm   = is_fast || is_phase;
	assign top_value = (is_pwm && waveform_mode_top_bit) ? compare_value_channel[0]
		: COUNT_MAX;
	assign at_top    = (timer_count_value == top_value);
	assign at_bottom = (timer_count_value == COUNT_BOTTOM);

	// ----------------------------------------------------------------
	// port grouping
	// ----------------------------------------------------------------
	assign int_ack    = {int_ack_b, int_ack_a};
	assign dir_out    = {dir_out_b, dir_out_a};
	assign port_value = {port_value_b, port_value_a};
	assign irq_a = irq[0];
	assign irq_b = irq[1];
	assign waveform_output_a = waveform_output_latch[0];
	assign waveform_output_b = waveform_output_latch[1];
	assign pin_out_a = pin_out[0];
	assign pin_out_b = pin_out[1];
	assign pin_oe_a  = dir_out[0];
	assign pin_oe_b  = dir_out[1];

	// ----------------------------------------------------------------
	// control and enable registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= CONTROL_RESET;
		end else if (clk_en && reg_write && reg_addr == REG_CONTROL) begin
			control <= reg_wdata & CONTROL_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_enable <= ENABLE_RESET;
		end else if (clk_en && reg_write && reg_addr == REG_INT_ENABLE) begin
			int_enable <= reg_wdata[CHANNELS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// match blocking after a count write
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			block_pending <= 1'b0;
		end else if (clk_en) begin
			if (count_write) begin
				block_pending <= 1'b1;
			end else if (timer_tick) begin
				block_pending <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel compare, flag and waveform logic
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		localparam logic [2:0] CMP_ADDR = (ch == 0) ? REG_COMPARE_A : REG_COMPARE_B;
		localparam logic       IS_A     = (ch == 0);

		assign compare_action_select[ch] = control[CTRL_ACT_LSB + 2 * ch +: 2];
		assign hit[ch] = timer_tick && !block_pending
			&& (timer_count_value == compare_value_channel[ch]);
		assign ignore_match[ch] = is_pwm && compare_action_select[ch][1]
			&& (compare_value_channel[ch] == top_value);
		assign force_compare_strobe[ch] = reg_write && reg_addr == REG_FORCE
			&& reg_wdata[ch] && !is_pwm;
		assign update_point[ch] = timer_tick && at_top;
		assign irq[ch] = compare_flag_channel[ch] && int_enable[ch];

		// pin override select
		assign connected[ch] = (compare_action_select[ch] != ACT_OFF)
			&& !(is_pwm && compare_action_select[ch] == ACT_TOGGLE
			&& !(IS_A && waveform_mode_top_bit));
		assign pin_out[ch] = connected[ch] ? waveform_output_latch[ch]
			: port_value[ch];

		// compare value and its buffer
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				compare_value_channel[ch] <= COMPARE_RESET;
				compare_buffer[ch]        <= COMPARE_RESET;
			end else if (clk_en) begin
				if (is_pwm && update_point[ch]) begin
					compare_value_channel[ch] <= compare_buffer[ch];
				end
				if (reg_write && reg_addr == CMP_ADDR) begin
					compare_buffer[ch] <= reg_wdata;
					if (!is_pwm) begin
						compare_value_channel[ch] <= reg_wdata;
					end
				end
			end
		end

		// match delay and flag
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				match_pend[ch] <= 1'b0;
			end else if (clk_en && timer_tick) begin
				match_pend[ch] <= hit[ch];
			end
		end

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				compare_flag_channel[ch] <= 1'b0;
			end else if (clk_en) begin
				if (timer_tick && match_pend[ch]) begin
					compare_flag_channel[ch] <= 1'b1;
				end else if (reg_write && reg_addr == REG_FLAGS && reg_wdata[ch]) begin
					compare_flag_channel[ch] <= 1'b0;
				end else if (int_ack[ch] && irq[ch]) begin
					compare_flag_channel[ch] <= 1'b0;
				end
			end
		end

		// symmetry tracking around bottom in phase correct mode
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				up_seen[ch] <= 1'b0;
				sym_fix[ch] <= 1'b0;
			end else if (clk_en && timer_tick && is_phase) begin
				if (at_top) begin
					up_seen[ch] <= 1'b0;
					sym_fix[ch] <= !up_seen[ch]
						&& (compare_buffer[ch] != top_value);
				end else if (at_bottom) begin
					sym_fix[ch] <= 1'b0;
				end else if (hit[ch] && !count_down) begin
					up_seen[ch] <= 1'b1;
				end
			end
		end

		// next waveform latch value
		always_comb begin
			next_latch[ch] = waveform_output_latch[ch];
			if (!is_pwm) begin
				if (hit[ch] || force_compare_strobe[ch]) begin
					unique case (compare_action_select[ch])
						ACT_OFF:    next_latch[ch] = waveform_output_latch[ch];
						ACT_TOGGLE: next_latch[ch] = !waveform_output_latch[ch];
						ACT_CLEAR:  next_latch[ch] = 1'b0;
						ACT_SET:    next_latch[ch] = 1'b1;
					endcase
				end
			end else if (is_fast) begin
				if (timer_tick && at_top && compare_action_select[ch][1]) begin
					next_latch[ch] = !compare_action_select[ch][0];
				end
				if (hit[ch] && !ignore_match[ch]) begin
					if (compare_action_select[ch] == ACT_TOGGLE) begin
						if (IS_A && waveform_mode_top_bit) begin
							next_latch[ch] = !waveform_output_latch[ch];
						end
					end else if (compare_action_select[ch][1]) begin
						next_latch[ch] = compare_action_select[ch][0];
					end
				end
			end else begin
				if (hit[ch] && !ignore_match[ch]) begin
					if (compare_action_select[ch] == ACT_TOGGLE) begin
						if (IS_A && waveform_mode_top_bit) begin
							next_latch[ch] = !waveform_output_latch[ch];
						end
					end else if (compare_action_select[ch][1]) begin
						next_latch[ch] = compare_action_select[ch][0] ^ count_down;
					end
				end
				if (timer_tick && at_top && ignore_match[ch]) begin
					next_latch[ch] = !compare_action_select[ch][0];
				end
				if (timer_tick && at_bottom && sym_fix[ch]
					&& compare_action_select[ch][1]) begin
					next_latch[ch] = compare_action_select[ch][0];
				end
			end
		end

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				waveform_output_latch[ch] <= 1'b0;
			end else if (clk_en) begin
				waveform_output_latch[ch] <= next_latch[ch];
			end
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			REG_CONTROL:    next_rdata = control;
			REG_COMPARE_A:  next_rdata = is_pwm ? compare_buffer[0]
				: compare_value_channel[0];
			REG_COMPARE_B:  next_rdata = is_pwm ? compare_buffer[1]
				: compare_value_channel[1];
			REG_FLAGS:      next_rdata[CHANNELS-1:0] = compare_flag_channel;
			REG_INT_ENABLE: next_rdata[CHANNELS-1:0] = int_enable;
			REG_STATUS: begin
				next_rdata[STAT_LATCH_LSB +: CHANNELS] = waveform_output_latch;
				next_rdata[STAT_BLOCK_BIT] = block_pending;
			end
			default:        next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? next_rdata : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_match_equal_count: assert property (
		(clk_en && timer_tick && !block_pending && !is_pwm && !force_compare_strobe[0]
		&& timer_count_value == compare_value_channel[0] && compare_action_select[0] == ACT_TOGGLE)
		|=> waveform_output_latch[0] != $past(waveform_output_latch[0]))
		else $error("equal count did not toggle the latch");

	a_flag_after_match: assert property (
		(clk_en && timer_tick && match_pend[0]) |=> compare_flag_channel[0])
		else $error("flag not set one tick after match");

	a_flag_not_early: assert property (
		(clk_en && timer_tick && hit[0] && !match_pend[0] && !compare_flag_channel[0])
		|=> !compare_flag_channel[0])
		else $error("flag set in the match tick");

	a_ack_clears_irq: assert property (
		(clk_en && int_ack_a && irq_a && !(timer_tick && match_pend[0]))
		|=> !irq_a && !compare_flag_channel[0])
		else $error("acknowledge did not clear the flag");

	a_one_clears_flag: assert property (
		(clk_en && reg_write && reg_addr == REG_FLAGS && reg_wdata[1]
		&& !(timer_tick && match_pend[1])) |=> !compare_flag_channel[1])
		else $error("writing one did not clear the flag");

	a_direct_write: assert property (
		(clk_en && reg_write && reg_addr == REG_COMPARE_A && !is_pwm)
		|=> compare_value_channel[0] == $past(reg_wdata))
		else $error("direct compare write lost");

	a_buffer_holds: assert property (
		(clk_en && reg_write && reg_addr == REG_COMPARE_B && is_pwm && !update_point[1])
		|=> compare_value_channel[1] == $past(compare_value_channel[1]))
		else $error("buffered write reached active compare early");

	a_force_no_flag: assert property (
		(clk_en && force_compare_strobe[0] && compare_action_select[0] == ACT_TOGGLE
		&& !hit[0] && !match_pend[0] && !compare_flag_channel[0])
		|=> waveform_output_latch[0] != $past(waveform_output_latch[0])
		&& !compare_flag_channel[0])
		else $error("force did not toggle or set the flag");

	a_block_after_write: assert property (
		(clk_en && count_write) |=> !hit[0] && !hit[1])
		else $error("match not blocked after count write");

	a_pin_override: assert property (
		(!is_pwm && compare_action_select[0] != ACT_OFF)
		|-> pin_out_a == waveform_output_latch[0] && pin_oe_a == dir_out_a)
		else $error("pin not driven from latch");

	a_fast_bottom_set: assert property (
		(clk_en && timer_tick && is_fast && at_top && !hit[0]
		&& compare_action_select[0] == ACT_CLEAR) |=> waveform_output_latch[0])
		else $error("latch not set at bottom");

endmodule

`default_nettype wire

// ### bench/port_pin_model.sv
// port pin model: port data bits, direction bits and a pulled-up pad
// assumes the compare block's pin outputs and bench control of port and direction
`timescale 1ns/10ps
`default_nettype none
module port_pin_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] port_set,
	input  wire logic [1:0] dir_set,
	input  wire logic       pin_out_a,
	input  wire logic       pin_oe_a,
	input  wire logic       pin_out_b,
	input  wire logic       pin_oe_b,
	output logic            port_value_a,
	output logic            port_value_b,
	output logic            dir_out_a,
	output logic            dir_out_b,
	output logic            pad_a,
	output logic            pad_b
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{port_value_b, port_value_a} <= 2'h0;
			{dir_out_b, dir_out_a}       <= 2'h0;
		end else begin
			{port_value_b, port_value_a} <= port_set;
			{dir_out_b, dir_out_a}       <= dir_set;
		end
	end
	// released pad settles at the pull-up level
	assign pad_a = pin_oe_a ? pin_out_a : 1'h1;
	assign pad_b = pin_oe_b ? pin_out_b : 1'h1;
endmodule
`default_nettype wire

// ### bench/timer_output_compare_waveform_tb.sv
// testbench for the output compare block with a port pin model
// assumes one 50 MHz clock and timer ticks made by the bench
`timescale 1ns/10ps
`default_nettype none
module timer_output_compare_waveform_tb import timer_compare_pkg::*;;
	logic core_clk = 1'h0, rst_n = 1'h0, tick_en = 1'h0, count_write = 1'h0;
	logic reg_write = 1'h0, reg_read = 1'h0, int_ack_a = 1'h0, count_down = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, count = 8'h00, reg_rdata;
	logic [1:0] port_set = 2'h0, dir_set = 2'h0;
	logic irq_a, irq_b, wave_a, wave_b, out_a, oe_a, out_b, oe_b;
	logic pv_a, pv_b, dir_a, dir_b, pad_a, pad_b;
	int   error_cnt = 0, checked = 0;
	always #10 core_clk = ~core_clk;
	timer_output_compare_waveform i_timer_output_compare_waveform (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'h1), .timer_tick(tick_en),
		.timer_count_value(count), .count_down(count_down), .count_write(count_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .int_ack_a(int_ack_a),
		.int_ack_b(1'h0), .irq_a(irq_a), .irq_b(irq_b), .port_value_a(pv_a),
		.port_value_b(pv_b), .dir_out_a(dir_a), .dir_out_b(dir_b),
		.waveform_output_a(wave_a), .waveform_output_b(wave_b), .pin_out_a(out_a),
		.pin_oe_a(oe_a), .pin_out_b(out_b), .pin_oe_b(oe_b));
	port_pin_model i_port_pin_model (
		.core_clk(core_clk), .rst_n(rst_n), .port_set(port_set), .dir_set(dir_set),
		.pin_out_a(out_a), .pin_oe_a(oe_a), .pin_out_b(out_b), .pin_oe_b(oe_b),
		.port_value_a(pv_a), .port_value_b(pv_b), .dir_out_a(dir_a),
		.dir_out_b(dir_b), .pad_a(pad_a), .pad_b(pad_b));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge core_clk);
		reg_write <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge core_clk);
		reg_read <= 1'h0;
		@(negedge core_clk);
		chk(nm, reg_rdata, e);
	endtask
	task automatic tick(input logic [7:0] c, input logic dn = 1'h0);
		@(posedge core_clk);
		count      <= c;
		count_down <= dn;
		tick_en    <= 1'h1;
		@(posedge core_clk);
		tick_en <= 1'h0;
		@(negedge core_clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd(REG_CONTROL, CONTROL_RESET, "control");
		rd(REG_COMPARE_A, COMPARE_RESET, "compare_a");
		rd(3'h7, 8'h00, "unmapped");
		chk("pad_a idle", {7'h0, pad_a}, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_normal;
		wr(REG_CONTROL, 8'h10);
		wr(REG_COMPARE_A, 8'h07);
		wr(REG_INT_ENABLE, 8'h03);
		tick(8'h07);
		chk("latch_a toggle", {7'h0, wave_a}, 8'h01);
		chk("pad_a latch", {7'h0, pad_a}, 8'h01);
		rd(REG_FLAGS, 8'h00, "flag early");
		tick(8'h08);
		chk("irq_a", {7'h0, irq_a}, 8'h01);
		wr(REG_FLAGS, 8'h00);
		rd(REG_FLAGS, 8'h01, "flag kept");
		wr(REG_FLAGS, 8'h01);
		rd(REG_FLAGS, 8'h00, "flag cleared");
		tick(8'h07);
		chk("latch_a toggle back", {7'h0, wave_a}, 8'h00);
		tick(8'h08);
		@(posedge core_clk);
		int_ack_a <= 1'h1;
		@(posedge core_clk);
		int_ack_a <= 1'h0;
		@(negedge core_clk);
		chk("irq_a after ack", {7'h0, irq_a}, 8'h00);
		$display("test normal done");
	endtask
	task automatic t_force;
		wr(REG_CONTROL, 8'h30);
		wr(REG_FORCE, 8'h01);
		@(negedge core_clk);
		chk("force set", {7'h0, wave_a}, 8'h01);
		rd(REG_FLAGS, 8'h00, "force no flag");
		wr(REG_CONTROL, 8'h20);
		wr(REG_FORCE, 8'h01);
		@(negedge core_clk);
		chk("force clear", {7'h0, wave_a}, 8'h00);
		port_set <= 2'h1;
		wr(REG_CONTROL, 8'h00);
		wr(REG_FORCE, 8'h01);
		@(negedge core_clk);
		chk("pad_a port", {7'h0, pad_a}, 8'h01);
		chk("latch_a idle", {7'h0, wave_a}, 8'h00);
		wr(REG_CONTROL, 8'h10);
		wr(REG_FORCE, 8'h01);
		@(negedge core_clk);
		chk("force toggle", {7'h0, wave_a}, 8'h01);
		wr(REG_FORCE, 8'h01);
		@(negedge core_clk);
		chk("force toggle back", {7'h0, wave_a}, 8'h00);
		$display("test force done");
	endtask
	task automatic t_block;
		wr(REG_CONTROL, 8'h10);
		// written count lands on the compare value
		@(posedge core_clk);
		count_write <= 1'h1;
		@(posedge core_clk);
		count_write <= 1'h0;
		tick(8'h07);
		chk("blocked latch", {7'h0, wave_a}, 8'h00);
		tick(8'h08);
		chk("blocked irq", {7'h0, irq_a}, 8'h00);
		tick(8'h07);
		chk("unblocked latch", {7'h0, wave_a}, 8'h01);
		$display("test block done");
	endtask
	task automatic t_fast;
		wr(REG_CONTROL, 8'h23);
		@(negedge core_clk);
		chk("mode change", {7'h0, wave_a}, 8'h01);
		wr(REG_COMPARE_A, 8'h05);
		tick(8'h05);
		chk("buffered", {7'h0, wave_a}, 8'h01);
		rd(REG_COMPARE_A, 8'h05, "buffer read");
		tick(8'hFF);
		tick(8'h05);
		chk("fast clear", {7'h0, wave_a}, 8'h00);
		tick(8'hFF);
		chk("fast bottom set", {7'h0, wave_a}, 8'h01);
		$display("test fast done");
	endtask
	task automatic t_phase;
		wr(REG_CONTROL, 8'hE1);
		wr(REG_COMPARE_B, 8'h03);
		tick(8'hFF);
		tick(8'h05, 1'h1);
		tick(8'h03, 1'h1);
		tick(8'h00, 1'h1);
		chk("pc fix a", {7'h0, wave_a}, 8'h00);
		chk("pc fix b", {7'h0, wave_b}, 8'h01);
		chk("pad_b latch", {7'h0, pad_b}, 8'h01);
		chk("irq_b", {7'h0, irq_b}, 8'h01);
		wr(REG_FLAGS, 8'h02);
		rd(REG_FLAGS, 8'h01, "flag b cleared");
		tick(8'h03);
		tick(8'h05);
		tick(8'hFF);
		tick(8'h05, 1'h1);
		chk("pc down set a", {7'h0, wave_a}, 8'h01);
		tick(8'h03, 1'h1);
		chk("pc down clear b", {7'h0, wave_b}, 8'h00);
		tick(8'h00, 1'h1);
		chk("pc bottom hold", {7'h0, wave_a}, 8'h01);
		$display("test phase done");
	endtask
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n   <= 1'h1;
		dir_set <= 2'h3;
		t_reset;
		t_normal;
		t_force;
		t_block;
		t_fast;
		t_phase;
		end_of_test;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		$display("timeout");
		end_of_test;
	end
endmodule
`default_nettype wire
